// ### common/capture_unit_consts.svh
// Offsets, field positions, reset values and timing counts of the capture unit
`ifndef CAPTURE_UNIT_CONSTS_SVH
`define CAPTURE_UNIT_CONSTS_SVH
`define OFS_CCP_CONTROL 8'h00
`define OFS_CAPTURE_VALUE_LOW 8'h04
`define OFS_CAPTURE_VALUE_HIGH 8'h08
`define OFS_AUTO_SHUTDOWN_CONTROL 8'h0C
`define OFS_PWM_PERIOD 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_CAPTURE_FLAG 8'h1C
`define OFS_PIN_CONTROL 8'h20
`define CCP_CONTROL_RESET 8'h00
`define AUTO_SHUTDOWN_RESET 8'h00
`define PWM_PERIOD_RESET 8'hFF
`define MODE_LSB 0
`define DUTY_LSB 4
`define ASE_BIT 7
`define AS_LSB 4
`define PSS_AC_LSB 2
`define PSS_BD_LSB 0
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_PWM 4'hC
`define PRESCALE_4 4'h3
`define PRESCALE_16 4'hF
`endif

// ### common/capture_unit_pkg.sv
// Types shared by the capture unit
`default_nettype none
package capture_unit_pkg;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_CMP1, SRC_CMP2, SRC_CMP_ANY,
    SRC_FAULT, SRC_FAULT_CMP1, SRC_FAULT_CMP2, SRC_RSVD
  } shutdown_src_t;
  typedef enum logic [1:0] {
    PSS_LOW, PSS_HIGH, PSS_TRI_A, PSS_TRI_B
  } shutdown_state_t;
endpackage
`default_nettype wire

// ### design/capture_and_pwm_shutdown_unit.sv
// Capture, PWM and auto-shutdown unit behind a classic Wishbone slave
`include "capture_unit_consts.svh"
`default_nettype none
module capture_and_pwm_shutdown_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [15:0] timebase_count_i,
  input wire logic sleep_i,
  input wire logic capture_input_pin_i,
  output logic capture_input_pin_o,
  output logic capture_input_pin_oe_o,
  input wire logic first_comparator_i,
  input wire logic second_comparator_i,
  input wire logic fault_input_pin_i,
  output logic pwm_out_a_o,
  output logic pwm_out_a_oe_o,
  output logic pwm_out_b_o,
  output logic pwm_out_b_oe_o,
  output logic pwm_out_c_o,
  output logic pwm_out_c_oe_o,
  output logic pwm_out_d_o,
  output logic pwm_out_d_oe_o,
  output logic irq_o
);
  import capture_unit_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ccp_control;
  logic [7:0] auto_shutdown_control;
  logic [7:0] capture_value_low;
  logic [7:0] capture_value_high;
  logic [7:0] pwm_period;
  logic [7:0] pwm_timebase_count;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic capture_irq_flag;
  logic [1:0] pin_control;
  logic [3:0] prescale_count;
  logic pin_prev;
  logic pwm_level;
  logic shutdown_event_status;
  logic shutdown_trigger;
  logic capture_event;
  logic qualified_edge;
  logic cap_mode;
  logic [3:0] unit_mode_field;
  logic [3:0] prescale_limit;
  logic bus_req;
  logic bus_hit;
  logic wr_en;
  logic rd_en;
  logic [31:0] next_rdata;
  shutdown_src_t src_sel;
  shutdown_state_t pss_ac;
  shutdown_state_t pss_bd;

  assign unit_mode_field = ccp_control[`MODE_LSB +: 4];
  assign src_sel = shutdown_src_t'(auto_shutdown_control[`AS_LSB +: 3]);
  assign pss_ac = shutdown_state_t'(auto_shutdown_control[`PSS_AC_LSB +: 2]);
  assign pss_bd = shutdown_state_t'(auto_shutdown_control[`PSS_BD_LSB +: 2]);
  assign cap_mode = (unit_mode_field >= `MODE_CAP_FALL) &&
                    (unit_mode_field <= `MODE_CAP_RISE16);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one registered ack a clock after the request (one wait state), dropped the cycle after
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  always_comb begin
    unique case (wb_adr_i)
      `OFS_CCP_CONTROL, `OFS_CAPTURE_VALUE_LOW, `OFS_CAPTURE_VALUE_HIGH,
      `OFS_AUTO_SHUTDOWN_CONTROL, `OFS_PWM_PERIOD, `OFS_IRQ_STATUS,
      `OFS_IRQ_MASK, `OFS_CAPTURE_FLAG, `OFS_PIN_CONTROL: bus_hit = 1'b1;
      default: bus_hit = 1'b0;
    endcase
  end
  assign wr_en = bus_req && bus_hit && wb_we_i && wb_sel_i[0];
  assign rd_en = bus_req && bus_hit && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && bus_hit;
      wb_err_o <= bus_req && !bus_hit;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFS_CCP_CONTROL: next_rdata[7:0] = ccp_control;
      `OFS_CAPTURE_VALUE_LOW: next_rdata[7:0] = capture_value_low;
      `OFS_CAPTURE_VALUE_HIGH: next_rdata[7:0] = capture_value_high;
      // bit 7 reads the latched shutdown status
      `OFS_AUTO_SHUTDOWN_CONTROL: next_rdata[7:0] =
        {shutdown_event_status, auto_shutdown_control[6:0]};
      `OFS_PWM_PERIOD: next_rdata[7:0] = pwm_period;
      `OFS_IRQ_STATUS: next_rdata[1:0] = irq_status;
      `OFS_IRQ_MASK: next_rdata[1:0] = irq_mask;
      `OFS_CAPTURE_FLAG: next_rdata[0] = capture_irq_flag;
      `OFS_PIN_CONTROL: next_rdata[1:0] = pin_control;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      wb_dat_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; all return to reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ccp_control <= `CCP_CONTROL_RESET;
      pwm_period <= `PWM_PERIOD_RESET;
      irq_mask <= 2'h0;
      pin_control <= 2'h0;
    end else if (wr_en && !sleep_i) begin
      if (wb_adr_i == `OFS_CCP_CONTROL) begin
        ccp_control <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `OFS_PWM_PERIOD) begin
        pwm_period <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `OFS_IRQ_MASK) begin
        irq_mask <= wb_dat_i[1:0];
      end
      if (wb_adr_i == `OFS_PIN_CONTROL) begin
        pin_control <= wb_dat_i[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture path
  // pin edges drive trigger, including the unit's own output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev <= 1'b0;
    end else if (!sleep_i) begin
      pin_prev <= capture_input_pin_i;
    end
  end

  always_comb begin
    qualified_edge = 1'b0;
    if (unit_mode_field == `MODE_CAP_FALL) begin
      qualified_edge = pin_prev && !capture_input_pin_i;
    end else if (cap_mode) begin
      qualified_edge = !pin_prev && capture_input_pin_i;
    end
  end

  always_comb begin
    prescale_limit = 4'h0;
    if (unit_mode_field == `MODE_CAP_RISE4) begin
      prescale_limit = `PRESCALE_4;
    end else if (unit_mode_field == `MODE_CAP_RISE16) begin
      prescale_limit = `PRESCALE_16;
    end
  end

  // mode or prescale changes are not filtered; >= may fire early
  assign capture_event = !sleep_i && qualified_edge &&
                         (prescale_count >= prescale_limit);

  // prescaler clears on reset, off, or non-capture mode
  always_ff @(posedge clk_i) begin
    if (rst_i || !cap_mode) begin
      prescale_count <= 4'h0;
    end else if (capture_event) begin
      prescale_count <= 4'h0;
    end else if (qualified_edge && !sleep_i) begin
      prescale_count <= prescale_count + 4'h1;
    end
  end

  // copy timer into holding pair; newer overwrites
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_value_low <= 8'h00;
      capture_value_high <= 8'h00;
    end else if (capture_event) begin
      capture_value_low <= timebase_count_i[7:0];
      capture_value_high <= timebase_count_i[15:8];
    end else if (wr_en && !sleep_i && !cap_mode) begin
      if (wb_adr_i == `OFS_CAPTURE_VALUE_LOW) begin
        capture_value_low <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `OFS_CAPTURE_VALUE_HIGH) begin
        capture_value_high <= wb_dat_i[7:0];
      end
    end
  end

  // flag set by hardware, cleared only by a software write; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_irq_flag <= 1'b0;
    end else if (capture_event) begin
      capture_irq_flag <= 1'b1;
    end else if (wr_en && !sleep_i && wb_adr_i == `OFS_CAPTURE_FLAG &&
                 !wb_dat_i[0]) begin
      capture_irq_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM time base
  // counts on the system clock; holds in sleep
  always_ff @(posedge clk_i) begin
    if (rst_i || unit_mode_field != `MODE_PWM) begin
      pwm_timebase_count <= 8'h00;
    end else if (!sleep_i) begin
      if (pwm_timebase_count >= pwm_period) begin
        pwm_timebase_count <= 8'h00;
      end else begin
        pwm_timebase_count <= pwm_timebase_count + 8'h01;
      end
    end
  end

  // Duty compares the upper control nibble with the count's top four bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_level <= 1'b0;
    end else if (!sleep_i) begin
      pwm_level <= (unit_mode_field == `MODE_PWM) &&
        (pwm_timebase_count[7:4] < ccp_control[`DUTY_LSB +: 4]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-shutdown
  // source selection; fault pin is active low
  always_comb begin
    unique case (src_sel)
      SRC_NONE: shutdown_trigger = 1'b0;
      SRC_CMP1: shutdown_trigger = first_comparator_i;
      SRC_CMP2: shutdown_trigger = second_comparator_i;
      SRC_CMP_ANY: shutdown_trigger = first_comparator_i ||
                                      second_comparator_i;
      SRC_FAULT: shutdown_trigger = !fault_input_pin_i;
      SRC_FAULT_CMP1: shutdown_trigger = !fault_input_pin_i ||
                                         first_comparator_i;
      SRC_FAULT_CMP2: shutdown_trigger = !fault_input_pin_i ||
                                         second_comparator_i;
      SRC_RSVD: shutdown_trigger = 1'b0;
    endcase
  end

  // status latches while shutdown holds; software clears it, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_shutdown_control <= `AUTO_SHUTDOWN_RESET;
      shutdown_event_status <= 1'b0;
    end else begin
      if (wr_en && !sleep_i && wb_adr_i == `OFS_AUTO_SHUTDOWN_CONTROL) begin
        auto_shutdown_control[6:0] <= wb_dat_i[6:0];
      end
      if (shutdown_trigger && !sleep_i) begin
        shutdown_event_status <= 1'b1;
      end else if (wr_en && !sleep_i &&
                   wb_adr_i == `OFS_AUTO_SHUTDOWN_CONTROL) begin
        shutdown_event_status <= wb_dat_i[`ASE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: bit0 capture, bit1 shutdown; read clears, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && capture_event) ||
            (i == 1 && shutdown_trigger && !shutdown_event_status &&
             !sleep_i)) begin
          irq_status[i] <= 1'b1;
        end else if (rd_en && wb_adr_i == `OFS_IRQ_STATUS) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Pins; reset leaves every pin as input
  // shutdown levels per pin pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_out_a_o <= 1'b0;
      pwm_out_c_o <= 1'b0;
      pwm_out_b_o <= 1'b0;
      pwm_out_d_o <= 1'b0;
      pwm_out_a_oe_o <= 1'b0;
      pwm_out_c_oe_o <= 1'b0;
      pwm_out_b_oe_o <= 1'b0;
      pwm_out_d_oe_o <= 1'b0;
    end else if (!sleep_i) begin
      if (shutdown_event_status) begin
        pwm_out_a_o <= pss_ac == PSS_HIGH;
        pwm_out_c_o <= pss_ac == PSS_HIGH;
        pwm_out_a_oe_o <= !auto_shutdown_control[`PSS_AC_LSB + 1];
        pwm_out_c_oe_o <= !auto_shutdown_control[`PSS_AC_LSB + 1];
        pwm_out_b_o <= pss_bd == PSS_HIGH;
        pwm_out_d_o <= pss_bd == PSS_HIGH;
        pwm_out_b_oe_o <= !auto_shutdown_control[`PSS_BD_LSB + 1];
        pwm_out_d_oe_o <= !auto_shutdown_control[`PSS_BD_LSB + 1];
      end else begin
        pwm_out_a_o <= pwm_level;
        pwm_out_c_o <= pwm_level;
        pwm_out_b_o <= !pwm_level;
        pwm_out_d_o <= !pwm_level;
        pwm_out_a_oe_o <= unit_mode_field == `MODE_PWM;
        pwm_out_c_oe_o <= unit_mode_field == `MODE_PWM;
        pwm_out_b_oe_o <= unit_mode_field == `MODE_PWM;
        pwm_out_d_oe_o <= unit_mode_field == `MODE_PWM;
      end
    end
  end

  // Capture pin as a port: bit0 drive enable, bit1 level
  assign capture_input_pin_oe_o = pin_control[0];
  assign capture_input_pin_o = pin_control[1];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_capture_copy;
    @(posedge clk_i) disable iff (rst_i)
    capture_event |=> capture_value_low == $past(timebase_count_i[7:0]) &&
                      capture_value_high == $past(timebase_count_i[15:8]);
  endproperty
  a_capture_copy: assert property (p_capture_copy)
    else $error("capture pair did not take the timer count");

  property p_rise16;
    @(posedge clk_i) disable iff (rst_i)
    capture_event && unit_mode_field == `MODE_CAP_RISE16 |->
      prescale_count == 4'hF;
  endproperty
  a_rise16: assert property (p_rise16)
    else $error("sixteenth-edge capture fired early");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
    capture_event |=> capture_irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("capture flag not set");

  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i)
    capture_irq_flag && !(wr_en && wb_adr_i == `OFS_CAPTURE_FLAG) |=>
      capture_irq_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("capture flag cleared without a write");

  property p_presc_clear;
    @(posedge clk_i) disable iff (rst_i)
    !cap_mode |=> prescale_count == 4'h0;
  endproperty
  a_presc_clear: assert property (p_presc_clear)
    else $error("prescaler not cleared outside capture");

  property p_sleep_freeze;
    @(posedge clk_i) disable iff (rst_i)
    sleep_i && $past(sleep_i) |-> $stable(pwm_timebase_count) &&
                                  $stable(pwm_out_a_o);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("unit changed during sleep");

  property p_shutdown_status;
    @(posedge clk_i) disable iff (rst_i)
    shutdown_trigger && !sleep_i |=> shutdown_event_status ##1
      (pwm_out_a_oe_o == !auto_shutdown_control[`PSS_AC_LSB + 1]);
  endproperty
  a_shutdown_status: assert property (p_shutdown_status)
    else $error("shutdown status or pins wrong");

  property p_fault_src;
    @(posedge clk_i) disable iff (rst_i)
    src_sel == SRC_FAULT && !fault_input_pin_i |-> shutdown_trigger;
  endproperty
  a_fault_src: assert property (p_fault_src)
    else $error("fault pin low did not trigger shutdown");

  property p_read_clean;
    @(posedge clk_i) disable iff (rst_i)
    rd_en && !capture_event |=> $stable(capture_value_low) &&
                                $stable(capture_irq_flag);
  endproperty
  a_read_clean: assert property (p_read_clean)
    else $error("read altered captured state");

  c_capture: cover property (@(posedge clk_i) disable iff (rst_i)
    capture_event && unit_mode_field == `MODE_CAP_RISE4);
  c_overwrite: cover property (@(posedge clk_i) disable iff (rst_i)
    capture_event && capture_irq_flag);
  c_shutdown: cover property (@(posedge clk_i) disable iff (rst_i)
    shutdown_event_status && pwm_out_b_oe_o);
endmodule
`default_nettype wire

// ### testbench/edge_fault_source.sv
// Far-side model: edge source on the capture pin, comparators and fault pin
`default_nettype none
module edge_fault_source (
  input wire logic clk_i,
  input wire logic drive_en_i,
  input wire logic drive_level_i,
  input wire logic dut_pin_i,
  input wire logic dut_pin_oe_i,
  input wire logic [2:0] trig_i,
  output logic pin_o,
  output logic first_comparator_o,
  output logic second_comparator_o,
  output logic fault_input_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_level;
  always_ff @(posedge clk_i) begin
    last_level <= pin_o;
  end
  // A floating pin keeps moving, so a stale level can never pass for a drive
  always_comb begin
    if (dut_pin_oe_i) begin
      pin_o = dut_pin_i;
    end else if (drive_en_i) begin
      pin_o = drive_level_i;
    end else begin
      pin_o = ~last_level;
    end
  end
  assign first_comparator_o = trig_i[0];
  assign second_comparator_o = trig_i[1];
  // Fault request drives the pin low
  assign fault_input_pin_o = ~trig_i[2];
endmodule
`default_nettype wire

// ### testbench/capture_and_pwm_shutdown_unit_test.sv
// Self-checking bench for the capture, PWM and auto-shutdown unit
`include "capture_unit_consts.svh"
`default_nettype none
module capture_and_pwm_shutdown_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic shut;
    logic [7:0] cfg;
    int pulses;
    logic [2:0] trig;
    logic exp;
  } row_t;
  logic clk_i = '0, rst_i = '1, wb_we_i = '0, wb_cyc_i = '0, wb_stb_i = '0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'hF;
  logic [15:0] timebase_count_i = 16'h0000, tb_exp, v;
  logic sleep_i = '0, drive_en = '1, drive_level = '0;
  logic wb_ack_o, wb_err_o, err, irq_o;
  logic [2:0] trig = 3'h0;
  logic pin, pin_o, pin_oe, cmp1, cmp2, flt;
  logic a, a_oe, b, b_oe, c, c_oe, d, d_oe;
  int error_cnt = 0, checked = 0;
  row_t rows[15] = '{
    '{1'h0, 8'h05, 1, 3'h0, 1'h1}, '{1'h0, 8'h06, 3, 3'h0, 1'h0},
    '{1'h0, 8'h06, 4, 3'h0, 1'h1}, '{1'h0, 8'h07, 15, 3'h0, 1'h0},
    '{1'h0, 8'h07, 16, 3'h0, 1'h1}, '{1'h0, 8'h04, 1, 3'h0, 1'h1},
    '{1'h1, 8'h00, 0, 3'h7, 1'h0}, '{1'h1, 8'h11, 0, 3'h1, 1'h1},
    '{1'h1, 8'h11, 0, 3'h2, 1'h0}, '{1'h1, 8'h24, 0, 3'h2, 1'h1},
    '{1'h1, 8'h3A, 0, 3'h2, 1'h1}, '{1'h1, 8'h56, 0, 3'h1, 1'h1},
    '{1'h1, 8'h69, 0, 3'h4, 1'h1}, '{1'h1, 8'h41, 0, 3'h4, 1'h1},
    '{1'h1, 8'h40, 0, 3'h3, 1'h0}
  };

  capture_and_pwm_shutdown_unit dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .timebase_count_i(timebase_count_i), .sleep_i(sleep_i),
    .capture_input_pin_i(pin), .capture_input_pin_o(pin_o),
    .capture_input_pin_oe_o(pin_oe), .first_comparator_i(cmp1),
    .second_comparator_i(cmp2), .fault_input_pin_i(flt),
    .pwm_out_a_o(a), .pwm_out_a_oe_o(a_oe), .pwm_out_b_o(b),
    .pwm_out_b_oe_o(b_oe), .pwm_out_c_o(c), .pwm_out_c_oe_o(c_oe),
    .pwm_out_d_o(d), .pwm_out_d_oe_o(d_oe), .irq_o(irq_o));

  edge_fault_source far (.clk_i(clk_i), .drive_en_i(drive_en),
    .drive_level_i(drive_level), .dut_pin_i(pin_o), .dut_pin_oe_i(pin_oe),
    .trig_i(trig), .pin_o(pin), .first_comparator_o(cmp1),
    .second_comparator_o(cmp2), .fault_input_pin_o(flt));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  // Classic cycle: hold everything until ack or err is sampled high
  task automatic bus(input logic [7:0] adr, input logic we,
                     input logic [7:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= {24'h0, dat};
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && n < 50);
    q = wb_dat_o;
    err = wb_err_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 50) begin
      error_cnt++;
      $display("mismatch at %0t: bus cycle never answered", $time);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] q;
    bus(adr, 1'h1, dat, q);
  endtask

  task automatic rd_reg(input logic [7:0] adr, output logic [31:0] q);
    bus(adr, 1'h0, 8'h00, q);
  endtask

  task automatic read_cap(output logic [15:0] val);
    logic [31:0] q;
    rd_reg(`OFS_CAPTURE_VALUE_LOW, q);
    val[7:0] = q[7:0];
    rd_reg(`OFS_CAPTURE_VALUE_HIGH, q);
    val[15:8] = q[7:0];
  endtask

  task automatic pulse();
    @(posedge clk_i);
    drive_level <= 1'h1;
    repeat (3) @(posedge clk_i);
    drive_level <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask

  // Clear the control register before each new capture setting
  task automatic set_mode(input logic [3:0] mode);
    wr(`OFS_CCP_CONTROL, 8'h00);
    wr(`OFS_CCP_CONTROL, {4'h0, mode});
    wr(`OFS_CAPTURE_FLAG, 8'h00);
  endtask

  task automatic check_pins(input logic [3:0] pss);
    check_bit(a_oe, ~pss[3]);
    check_bit(c_oe, ~pss[3]);
    check_bit(b_oe, ~pss[1]);
    check_bit(d_oe, ~pss[1]);
    if (!pss[3]) begin
      check_bit(a, pss[2]);
      check_bit(c, pss[2]);
    end
    if (!pss[1]) begin
      check_bit(b, pss[0]);
      check_bit(d, pss[0]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (rows[i]) begin
      if (!rows[i].shut) begin
        tb_exp = 16'hA000 + 16'(i);
        // timer held synchronous to the system clock
        timebase_count_i <= tb_exp;
        // control cleared, then flag cleared after the change
        set_mode(rows[i].cfg[3:0]);
        repeat (rows[i].pulses) pulse();
        rd_reg(`OFS_CAPTURE_FLAG, rd);
        check_bit(rd[0], rows[i].exp);
        if (rows[i].exp) begin
          read_cap(v);
          check_val(v, tb_exp);
        end
      end else begin
        wr(`OFS_CCP_CONTROL, {4'h0, `MODE_PWM});
        wr(`OFS_AUTO_SHUTDOWN_CONTROL, rows[i].cfg);
        trig <= rows[i].trig;
        repeat (4) @(posedge clk_i);
        if (rows[i].exp) begin
          check_pins(rows[i].cfg[3:0]);
        end
        rd_reg(`OFS_AUTO_SHUTDOWN_CONTROL, rd);
        check_bit(rd[`ASE_BIT], rows[i].exp);
        trig <= 3'h0;
        repeat (4) @(posedge clk_i);
        wr(`OFS_AUTO_SHUTDOWN_CONTROL, rows[i].cfg);
      end
    end
    // Newest capture wins; reads leave value and flag alone
    set_mode(`MODE_CAP_RISE);
    wr(`OFS_IRQ_MASK, 8'h01);
    rd_reg(`OFS_IRQ_STATUS, rd);
    timebase_count_i <= 16'hBEEF;
    pulse();
    check_bit(irq_o, 1'h1);
    timebase_count_i <= 16'h7C01;
    pulse();
    read_cap(v);
    check_val(v, 16'h7C01);
    read_cap(v);
    check_val(v, 16'h7C01);
    rd_reg(`OFS_IRQ_STATUS, rd);
    @(posedge clk_i);
    check_bit(irq_o, 1'h0);
    wr(`OFS_IRQ_MASK, 8'h00);
    pulse();
    check_bit(irq_o, 1'h0);
    repeat (20) @(posedge clk_i);
    rd_reg(`OFS_CAPTURE_FLAG, rd);
    check_bit(rd[0], 1'h1);
    wr(`OFS_CAPTURE_FLAG, 8'h00);
    rd_reg(`OFS_CAPTURE_FLAG, rd);
    check_bit(rd[0], 1'h0);
    // Unit drives its own pin and catches the edge it makes
    wr(`OFS_PIN_CONTROL, 8'h01);
    drive_en <= 1'h0;
    wr(`OFS_CAPTURE_FLAG, 8'h00);
    timebase_count_i <= 16'h0D05;
    wr(`OFS_PIN_CONTROL, 8'h03);
    repeat (4) @(posedge clk_i);
    read_cap(v);
    check_val(v, 16'h0D05);
    drive_en <= 1'h1;
    wr(`OFS_PIN_CONTROL, 8'h00);
    // Switching off discards a partial prescale count
    set_mode(`MODE_CAP_RISE4);
    pulse();
    pulse();
    set_mode(`MODE_CAP_RISE4);
    repeat (3) pulse();
    rd_reg(`OFS_CAPTURE_FLAG, rd);
    check_bit(rd[0], 1'h0);
    pulse();
    rd_reg(`OFS_CAPTURE_FLAG, rd);
    check_bit(rd[0], 1'h1);
    // Sleep freezes capture and blocks register writes
    set_mode(`MODE_CAP_RISE);
    sleep_i <= 1'h1;
    pulse();
    wr(`OFS_CCP_CONTROL, 8'h00);
    sleep_i <= 1'h0;
    rd_reg(`OFS_CAPTURE_FLAG, rd);
    check_bit(rd[0], 1'h0);
    rd_reg(`OFS_CCP_CONTROL, rd);
    check_val({8'h00, rd[7:0]}, 16'h0005);
    bus(8'hFC, 1'h0, 8'h00, rd);
    check_bit(err, 1'h1);
    // Second reset in mid-run
    wr(`OFS_AUTO_SHUTDOWN_CONTROL, 8'h15);
    wr(`OFS_PWM_PERIOD, 8'h40);
    rst_i <= 1'h1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    check_pins(4'hA);
    check_bit(pin_oe, 1'h0);
    rd_reg(`OFS_CCP_CONTROL, rd);
    check_val({8'h00, rd[7:0]}, 16'h0000);
    rd_reg(`OFS_AUTO_SHUTDOWN_CONTROL, rd);
    check_val({8'h00, rd[7:0]}, 16'h0000);
    rd_reg(`OFS_PWM_PERIOD, rd);
    check_val({8'h00, rd[7:0]}, 16'h00FF);
    tally_and_finish();
  end
endmodule
`default_nettype wire
